//--- rtl/cidf_pkg.sv
/*
 * Constants for the identifier filter and bit-time block: register map,
 * field positions, reset values and encodings.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
package cidf_pkg;
    // Word byte addresses.
    localparam logic [7:0] CIDF_ADR_CTL0 = 8'h00;
    localparam logic [7:0] CIDF_ADR_CTL1 = 8'h04;
    localparam logic [7:0] CIDF_ADR_BTR0 = 8'h08;
    localparam logic [7:0] CIDF_ADR_BTR1 = 8'h0c;
    localparam logic [7:0] CIDF_ADR_RFLG = 8'h10;
    localparam logic [7:0] CIDF_ADR_IDAC = 8'h14;
    localparam logic [7:0] CIDF_ADR_ERRC = 8'h18;
    localparam logic [7:0] CIDF_ADR_PAT0 = 8'h20;
    localparam logic [7:0] CIDF_ADR_MSK0 = 8'h40;
    // Control register zero bits.
    localparam int CIDF_B_INIT_REQUEST_BIT = 0;
    localparam int CIDF_B_PDN = 1;
    localparam int CIDF_B_NORMAL = 2;
    // Control register one bits.
    localparam int CIDF_B_INIT_ACKNOWLEDGE_BIT = 0;
    localparam int CIDF_B_CLOCK_SOURCE_SELECT = 6;
    localparam int CIDF_B_ENABLE = 7;
    // Bus timing register zero: prescaler minus one [5:0], jump width [7:6].
    localparam int CIDF_B_SJW = 6;
    // Bus timing register one: seg1 [3:0], seg2 [6:4], three samples [7].
    localparam int CIDF_B_SEG2 = 4;
    localparam int CIDF_B_SAMP = 7;
    // Acceptance control: mode [5:4], hit index [2:0].
    localparam int CIDF_B_MODE = 4;
    localparam logic [7:0] CIDF_CTL0_RST = 8'h01;
    localparam logic [7:0] CIDF_CTL1_RST = 8'h01;
    localparam logic [7:0] CIDF_BTR1_RST = 8'h23;
    typedef enum logic [1:0] {
        CIDF_M32 = 2'h0, CIDF_M16 = 2'h1, CIDF_M8 = 2'h2, CIDF_MCLOSED = 2'h3
    } cidf_mode_e;
    // Bit-time phases; Gray codes along sync, seg1, seg2.
    typedef enum logic [1:0] {
        CIDF_SYNC = 2'h0, CIDF_SEG1 = 2'h1, CIDF_SEG2 = 2'h3, CIDF_IDLE = 2'h2
    } cidf_phase_e;
endpackage

//--- rtl/cidf_core.sv
/*
 * Identifier acceptance filter, configuration lock and bit-time generator.
 * Assumes a classic Wishbone master on mclk, identifier frames delivered
 * by an external protocol engine with a one-cycle done strobe, and an
 * oscillator clock enable that is synchronous to mclk.
 */
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cidf_core
    import cidf_pkg::*;
#(
    parameter int PRESC_W = 6
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic osc_clk_en,
    input wire logic rx_done,
    input wire logic rx_ok,
    input wire logic [31:0] rx_idr,
    input wire logic tx_bit,
    input wire logic rx_pin,
    output logic bus_tx_output,
    output logic rx_buffer_full_flag,
    output logic sample_pulse,
    output logic sampled_bit,
    output logic tq_tick
);
    // The prescaler field shares its byte with the jump width above it.
    if (PRESC_W < 1 || PRESC_W > CIDF_B_SJW) begin : g_bad_presc
        $error("PRESC_W must be 1 to 6");
    end

    logic [7:0] ctl0_reg, ctl1_reg, btr0_reg, btr1_reg, idac_reg;
    logic [7:0] pat_reg [8];
    logic [7:0] msk_reg [8];
    logic enable_written_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic [3:0] tq_cnt_reg;
    cidf_phase_e phase_reg;
    logic [2:0] samp_hist_reg;
    logic [7:0] hits;
    logic [2:0] hit_idx;
    logic any_hit;
    logic accept;
    cidf_mode_e mode;

    wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic wr = bus_req & wb_we_i & wb_sel_i[0];
    wire logic init_ak = ctl1_reg[CIDF_B_INIT_ACKNOWLEDGE_BIT];
    wire logic cfg_wr = wr & init_ak;
    wire logic [7:0] wd = wb_dat_i[7:0];

    // Single-word match of the pattern and mask register windows.
    function automatic logic win_hit(input logic [7:0] a,
                                     input logic [7:0] base, input int i);
        win_hit = (a == base + 8'(i * 4));
    endfunction

    // Masked compare: mask bits set mean don't-care.
    function automatic logic mcmp(input logic [7:0] id, input logic [7:0] p,
                                  input logic [7:0] m);
        mcmp = ((id ^ p) & ~m) == 8'h00;
    endfunction

    // Identifier byte that filter g sees: all four bytes in 32-bit mode,
    // the first two in 16-bit mode and only the first in 8-bit mode.
    function automatic logic [7:0] id_byte(input logic [31:0] idr,
                                           input cidf_mode_e md,
                                           input int g);
        int lane;
        lane = 0;
        if (md == CIDF_M32) begin
            lane = g % 4;
        end else if (md == CIDF_M16) begin
            lane = g % 2;
        end
        id_byte = idr[31 - 8 * lane -: 8];
    endfunction

    // Bus slave answers every request one cycle later, unmapped reads zero.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Control zero is always writable; init acknowledge follows the request.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl0_reg <= CIDF_CTL0_RST;
        end else if (wr && wb_adr_i == CIDF_ADR_CTL0) begin
            ctl0_reg <= wd;
        end
    end

    // Locked configuration; the enable bit takes one write only once the control zero normal bit is set.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl1_reg <= CIDF_CTL1_RST;
            enable_written_reg <= 1'b0;
        end else begin
            ctl1_reg[CIDF_B_INIT_ACKNOWLEDGE_BIT] <= ctl0_reg[CIDF_B_INIT_REQUEST_BIT];
            if (cfg_wr && wb_adr_i == CIDF_ADR_CTL1) begin
                ctl1_reg[CIDF_B_ENABLE-1:1] <= wd[CIDF_B_ENABLE-1:1];
            end
            if (wr && wb_adr_i == CIDF_ADR_CTL1 && !enable_written_reg) begin
                ctl1_reg[CIDF_B_ENABLE] <= wd[CIDF_B_ENABLE];
                enable_written_reg <= ctl0_reg[CIDF_B_NORMAL];
            end
        end
    end

    // Timing and acceptance registers, writable only in init mode.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            btr0_reg <= 8'h00;
            btr1_reg <= CIDF_BTR1_RST;
            idac_reg <= 8'h00;
        end else begin
            if (cfg_wr && wb_adr_i == CIDF_ADR_BTR0) begin
                btr0_reg <= wd;
            end
            if (cfg_wr && wb_adr_i == CIDF_ADR_BTR1) begin
                btr1_reg <= wd;
            end
            if (cfg_wr && wb_adr_i == CIDF_ADR_IDAC) begin
                idac_reg[7:3] <= wd[7:3]; // Hit index is read-only.
            end else if (accept) begin
                idac_reg[2:0] <= hit_idx;
            end
        end
    end

    // Eight pattern and eight mask bytes, each a word of its own.
    for (genvar g = 0; g < 8; g++) begin : g_filt_regs
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                pat_reg[g] <= 8'h00;
                msk_reg[g] <= 8'h00;
            end else if (cfg_wr) begin
                if (win_hit(wb_adr_i, CIDF_ADR_PAT0, g)) begin
                    pat_reg[g] <= wd;
                end
                if (win_hit(wb_adr_i, CIDF_ADR_MSK0, g)) begin
                    msk_reg[g] <= wd;
                end
            end
        end
    end

    // Byte-wise compare of the received identifier against each bank byte.
    // rx_idr holds the four identifier bytes in frame order, byte 0 first.
    assign mode = cidf_mode_e'(idac_reg[CIDF_B_MODE +: 2]);
    logic [7:0] byte_ok;
    for (genvar g = 0; g < 8; g++) begin : g_cmp
        assign byte_ok[g] = mcmp(id_byte(rx_idr, mode, g), pat_reg[g],
                                 msk_reg[g]);
    end

    // Section hits per mode, then lowest-numbered match wins.
    always_comb begin
        hits = 8'h00;
        case (mode)
            CIDF_M32: begin
                hits[0] = &byte_ok[3:0];
                hits[1] = &byte_ok[7:4];
            end
            CIDF_M16: begin
                hits[0] = &byte_ok[1:0];
                hits[1] = &byte_ok[3:2];
                hits[2] = &byte_ok[5:4];
                hits[3] = &byte_ok[7:6];
            end
            CIDF_M8: hits = {byte_ok[7:4], byte_ok[3:0]};
            default: hits = 8'h00;
        endcase
        any_hit = |hits;
        hit_idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (hits[i]) begin
                hit_idx = 3'(i);
            end
        end
    end
    assign accept = rx_done & rx_ok & any_hit & ~init_ak;

    // Receive-full: set wins over software clear (write one to clear).
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rx_buffer_full_flag <= 1'b0;
        end else if (accept) begin
            rx_buffer_full_flag <= 1'b1;
        end else if (wr && wb_adr_i == CIDF_ADR_RFLG && wd[0]) begin
            rx_buffer_full_flag <= 1'b0;
        end
    end

    // Quantum tick from the selected protocol clock. Bus clock is mclk.
    wire logic pclk_en = ctl1_reg[CIDF_B_CLOCK_SOURCE_SELECT] ? 1'b1 : osc_clk_en;
    wire logic running = ctl1_reg[CIDF_B_ENABLE] & ~init_ak;
    always_ff @(posedge mclk) begin
        if (!rst_b || !running) begin
            presc_reg <= '0;
            tq_tick <= 1'b0;
        end else begin
            tq_tick <= 1'b0;
            if (pclk_en) begin
                if (presc_reg >= btr0_reg[PRESC_W-1:0]) begin
                    presc_reg <= '0;
                    tq_tick <= 1'b1;
                end else begin
                    presc_reg <= presc_reg + 1'b1;
                end
            end
        end
    end

    // Phase sequencer: one sync quantum, then seg1 and seg2 of field+1.
    wire logic [3:0] seg1_last = btr1_reg[3:0];
    wire logic [3:0] seg2_last = {1'b0, btr1_reg[CIDF_B_SEG2 +: 3]};
    wire logic [1:0] sjw_len = btr0_reg[CIDF_B_SJW +: 2];
    always_ff @(posedge mclk) begin
        if (!rst_b || !running) begin
            phase_reg <= CIDF_IDLE;
            tq_cnt_reg <= 4'h0;
        end else if (tq_tick) begin
            case (phase_reg)
                CIDF_SYNC: begin
                    phase_reg <= CIDF_SEG1;
                    tq_cnt_reg <= 4'h0;
                end
                CIDF_SEG1: begin
                    if (tq_cnt_reg == seg1_last) begin
                        phase_reg <= CIDF_SEG2;
                        tq_cnt_reg <= 4'h0;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + 4'h1;
                    end
                end
                CIDF_SEG2: begin
                    if (tq_cnt_reg == seg2_last) begin
                        phase_reg <= CIDF_SYNC;
                        tq_cnt_reg <= 4'h0;
                    end else begin
                        tq_cnt_reg <= tq_cnt_reg + 4'h1;
                    end
                end
                default: phase_reg <= CIDF_SYNC;
            endcase
        end
    end

    // Sample at end of seg1; with three samples take the majority there.
    wire logic samp_now = tq_tick && phase_reg == CIDF_SEG1 &&
                          tq_cnt_reg == seg1_last;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            samp_hist_reg <= 3'h7;
            sample_pulse <= 1'b0;
            sampled_bit <= 1'b1;
        end else begin
            sample_pulse <= samp_now;
            if (tq_tick) begin
                samp_hist_reg <= {samp_hist_reg[1:0], rx_pin};
            end
            if (samp_now) begin
                if (btr1_reg[CIDF_B_SAMP]) begin
                    sampled_bit <= (samp_hist_reg[1] & samp_hist_reg[0]) |
                                   (samp_hist_reg[1] & rx_pin) |
                                   (samp_hist_reg[0] & rx_pin);
                end else begin
                    sampled_bit <= rx_pin;
                end
            end
        end
    end

    // Transmit drives a new bit at the start of sync; recessive when offline.
    always_ff @(posedge mclk) begin
        if (!rst_b || init_ak || ctl0_reg[CIDF_B_INIT_REQUEST_BIT] ||
            ctl0_reg[CIDF_B_PDN] || !running) begin
            bus_tx_output <= 1'b1;
        end else if (tq_tick && phase_reg == CIDF_SEG2 &&
                     tq_cnt_reg == seg2_last) begin
            bus_tx_output <= tx_bit;
        end
    end

    // Read mux; error counters read zero and writes there do nothing.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= 32'h0;
            case (wb_adr_i)
                CIDF_ADR_CTL0: wb_dat_o[7:0] <= ctl0_reg;
                CIDF_ADR_CTL1: wb_dat_o[7:0] <= ctl1_reg;
                CIDF_ADR_BTR0: wb_dat_o[7:0] <= btr0_reg;
                CIDF_ADR_BTR1: wb_dat_o[7:0] <= btr1_reg;
                CIDF_ADR_RFLG: wb_dat_o[0] <= rx_buffer_full_flag;
                CIDF_ADR_IDAC: wb_dat_o[7:0] <= idac_reg;
                CIDF_ADR_ERRC: wb_dat_o <= 32'h0;
                default: begin
                    for (int i = 0; i < 8; i++) begin
                        if (win_hit(wb_adr_i, CIDF_ADR_PAT0, i)) begin
                            wb_dat_o[7:0] <= pat_reg[i];
                        end
                        if (win_hit(wb_adr_i, CIDF_ADR_MSK0, i)) begin
                            wb_dat_o[7:0] <= msk_reg[i];
                        end
                    end
                end
            endcase
        end
    end

    // Checks beside the logic.
    a_lock_btr: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (wr && !init_ak && wb_adr_i == CIDF_ADR_BTR1) |=> $stable(btr1_reg))
        else $error("timing register changed outside init");
    a_closed_noflag: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (mode == CIDF_MCLOSED && !rx_buffer_full_flag) |=>
        !rx_buffer_full_flag)
        else $error("closed filter set receive flag");
    a_accept_flag: assert property (@(posedge mclk)
        disable iff (!rst_b)
        accept |=> rx_buffer_full_flag && idac_reg[2:0] == $past(hit_idx))
        else $error("acceptance did not latch");
    a_tx_recessive: assert property (@(posedge mclk)
        disable iff (!rst_b)
        ctl0_reg[CIDF_B_INIT_REQUEST_BIT] |=> bus_tx_output)
        else $error("transmit not recessive in init");
    a_flag_cause: assert property (@(posedge mclk)
        disable iff (!rst_b)
        $rose(rx_buffer_full_flag) |-> $past(accept))
        else $error("flag set without accepted message");
    a_sync_one: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (tq_tick && phase_reg == CIDF_SYNC) |=> phase_reg == CIDF_SEG1)
        else $error("sync segment longer than one quantum");
    a_enable_once: assert property (@(posedge mclk)
        disable iff (!rst_b)
        enable_written_reg |=> $stable(ctl1_reg[CIDF_B_ENABLE]))
        else $error("enable bit rewritten");
    a_low_priority: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (hits[0]) |-> hit_idx == 3'h0)
        else $error("lowest filter not reported");
    // A transmit level change anywhere but the transmit point would
    // corrupt the bit that the other nodes are sampling.
    a_tx_hold: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (running && !init_ak && !ctl0_reg[CIDF_B_INIT_REQUEST_BIT] &&
         !ctl0_reg[CIDF_B_PDN] && !(tq_tick && phase_reg == CIDF_SEG2 &&
         tq_cnt_reg == seg2_last)) |=> $stable(bus_tx_output))
        else $error("transmit changed away from the transmit point");
    a_presc_hold: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (running && !pclk_en) |=> presc_reg == $past(presc_reg))
        else $error("prescaler ran without a protocol clock");
    a_errc_read: assert property (@(posedge mclk)
        disable iff (!rst_b)
        (bus_req && wb_adr_i == CIDF_ADR_ERRC) |=> wb_dat_o == 32'h0)
        else $error("error counter read not zero");
    c_accept: cover property (@(posedge mclk) accept);
    c_sample: cover property (@(posedge mclk) sample_pulse);
    c_multi: cover property (@(posedge mclk) accept && hits[1] && hits[0]);
    c_three: cover property (@(posedge mclk)
        samp_now && btr1_reg[CIDF_B_SAMP]);
    c_pair: cover property (@(posedge mclk) accept && mode == CIDF_M16);
endmodule // cidf_core
`default_nettype wire

//--- bench/cidf_bus_node.sv
/*
 * Behavioural model of the bus as seen through a transceiver, with one
 * remote node that can pull the line dominant on command.
 * Assumes the bench drives node_dom off the rising edge of mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module cidf_bus_node (
    input wire logic mclk,
    input wire logic bus_tx_output,
    input wire logic node_dom,
    output logic rx_pin
);
    // Wired-AND: a dominant zero from either node wins; a released bus
    // floats back to the recessive level through the bus termination.
    always_comb begin
        rx_pin = bus_tx_output & ~node_dom;
    end
endmodule // cidf_bus_node
`default_nettype wire

//--- bench/cidf_core_tb_top.sv
/*
 * Self-checking bench for the filter, configuration lock and bit timing.
 * Assumes cidf_core answers every Wishbone access with one ack pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module cidf_core_tb_top;
    import cidf_pkg::*;
    `define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
        err_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
    typedef struct packed {
        cidf_mode_e m; logic [31:0] id; logic ok; logic fl; logic [2:0] h;
    } cidf_case_s;
    logic mclk, rst_b, cyc, stb, we, osc_en, rx_done, rx_ok, tx_bit;
    logic node_dom, rx_pin, ack, tx, flag, spl, sbit, tick;
    logic [7:0] adr, q;
    logic [31:0] wdat, rdat, rx_idr;
    int err_count = 0;
    int checks_done = 0;
    int n;
    cidf_mode_e cur;
    cidf_case_s cs [17] = '{
        '{CIDF_M32, 32'h11223349, 1'h1, 1'h1, 3'h0},
        '{CIDF_M32, 32'h556677ab, 1'h1, 1'h1, 3'h1},
        '{CIDF_M32, 32'h55660088, 1'h1, 1'h0, 3'h0},
        '{CIDF_M32, 32'h11223344, 1'h0, 1'h0, 3'h0},
        '{CIDF_M16, 32'h11220000, 1'h1, 1'h1, 3'h0},
        '{CIDF_M16, 32'h33470000, 1'h1, 1'h1, 3'h1},
        '{CIDF_M16, 32'h55660000, 1'h1, 1'h1, 3'h2},
        '{CIDF_M16, 32'h77ab0000, 1'h1, 1'h1, 3'h3},
        '{CIDF_M8, 32'h11000000, 1'h1, 1'h1, 3'h0},
        '{CIDF_M8, 32'h22000000, 1'h1, 1'h1, 3'h1},
        '{CIDF_M8, 32'h33000000, 1'h1, 1'h1, 3'h2},
        '{CIDF_M8, 32'h47000000, 1'h1, 1'h1, 3'h3},
        '{CIDF_M8, 32'h55000000, 1'h1, 1'h1, 3'h4},
        '{CIDF_M8, 32'h66000000, 1'h1, 1'h1, 3'h5},
        '{CIDF_M8, 32'h77000000, 1'h1, 1'h1, 3'h6},
        '{CIDF_M8, 32'h99000000, 1'h1, 1'h1, 3'h7},
        '{CIDF_MCLOSED, 32'h11223344, 1'h1, 1'h0, 3'h0}
    };
    cidf_core dut_u (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .osc_clk_en(osc_en), .rx_done(rx_done), .rx_ok(rx_ok),
        .rx_idr(rx_idr), .tx_bit(tx_bit), .rx_pin(rx_pin),
        .bus_tx_output(tx), .rx_buffer_full_flag(flag),
        .sample_pulse(spl), .sampled_bit(sbit), .tq_tick(tick));
    cidf_bus_node node_u (.mclk(mclk), .bus_tx_output(tx),
        .node_dom(node_dom), .rx_pin(rx_pin));
    // Free-running 25 MHz system clock.
    initial begin
        mclk = 1'h0;
        forever #20 mclk = ~mclk;
    end
    // One classic cycle; the request is held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [7:0] d, output logic [7:0] r);
        int k;
        k = 0;
        @(posedge mclk);
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= {24'h0, d};
        do begin @(posedge mclk); k++; end while (ack !== 1'h1 && k < 50);
        r = rdat[7:0];
        cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
        if (k >= 50) `CHK(ack, 1'h1)
    endtask
    // Request or leave init mode and wait, bounded, for the acknowledge.
    task automatic set_init(input logic on);
        logic [7:0] r;
        int k;
        wb(1'h1, CIDF_ADR_CTL0, {5'h0, 1'h1, 1'h0, on}, r);
        k = 0;
        do begin wb(1'h0, CIDF_ADR_CTL1, 8'h00, r); k++; end
        while (r[CIDF_B_INIT_ACKNOWLEDGE_BIT] !== on && k < 20);
        `CHK(r[CIDF_B_INIT_ACKNOWLEDGE_BIT], on)
    endtask
    // Cycles between two pulses of the quantum tick or sample strobe.
    task automatic gap(input logic w, output int c);
        int k;
        k = 0;
        do begin @(posedge mclk); k++; end
        while ((w ? spl : tick) !== 1'h1 && k < 300);
        c = 0;
        do begin @(posedge mclk); c++; end
        while ((w ? spl : tick) !== 1'h1 && c < 300);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs a few thousand cycles at most.
    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        wrap_up;
    end
    // Main sequence.
    initial begin
        rst_b = 1'h0; cyc = 1'h0; stb = 1'h0; we = 1'h0; adr = 8'h00;
        wdat = 32'h0; osc_en = 1'h0; rx_done = 1'h0; rx_ok = 1'h0;
        rx_idr = 32'h0; tx_bit = 1'h0; node_dom = 1'h0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'h1;
        repeat (3) @(posedge mclk);
        wb(1'h0, CIDF_ADR_CTL1, 8'h00, q); `CHK(q, CIDF_CTL1_RST)
        wb(1'h0, CIDF_ADR_BTR1, 8'h00, q); `CHK(q, CIDF_BTR1_RST)
        wb(1'h1, CIDF_ADR_ERRC, 8'hff, q);
        wb(1'h0, CIDF_ADR_ERRC, 8'h00, q); `CHK(q, 8'h00)
        wb(1'h0, 8'hfc, 8'h00, q); `CHK(q, 8'h00)
        `CHK(tx, 1'h1)
        $display("test reset_values done");
        set_init(1'h1);
        wb(1'h1, CIDF_ADR_CTL1, 8'hc0, q);
        wb(1'h1, CIDF_ADR_CTL1, 8'h40, q);
        wb(1'h0, CIDF_ADR_CTL1, 8'h00, q); `CHK(q, 8'hc1)
        wb(1'h1, CIDF_ADR_BTR0, 8'h02, q);
        wb(1'h1, CIDF_ADR_BTR1, 8'h13, q);
        wb(1'h0, CIDF_ADR_BTR1, 8'h00, q); `CHK(q, 8'h13)
        for (int i = 0; i < 8; i++) begin
            wb(1'h1, CIDF_ADR_PAT0 + 8'(4 * i), 8'(8'h11 * (i + 1)), q);
            wb(1'h1, CIDF_ADR_MSK0 + 8'(4 * i),
                i == 3 ? 8'h0f : (i == 7 ? 8'hff : 8'h00), q);
        end
        cur = CIDF_MCLOSED;
        // Every filter mode, with masks, overlaps and a bad frame.
        foreach (cs[i]) begin
            if (cs[i].m != cur) begin
                set_init(1'h1);
                wb(1'h1, CIDF_ADR_IDAC, {2'h0, cs[i].m, 4'h0}, q);
                set_init(1'h0);
                cur = cs[i].m;
            end
            @(posedge mclk);
            rx_done <= 1'h1; rx_ok <= cs[i].ok; rx_idr <= cs[i].id;
            @(posedge mclk);
            rx_done <= 1'h0;
            repeat (2) @(posedge mclk);
            `CHK(flag, cs[i].fl)
            if (cs[i].fl) begin
                wb(1'h0, CIDF_ADR_IDAC, 8'h00, q);
                `CHK(q[2:0], cs[i].h)
                wb(1'h1, CIDF_ADR_RFLG, 8'h01, q);
                @(posedge mclk);
                `CHK(flag, 1'h0)
            end
        end
        $display("test filter_modes done");
        wb(1'h1, CIDF_ADR_BTR1, 8'h55, q);
        wb(1'h0, CIDF_ADR_BTR1, 8'h00, q); `CHK(q, 8'h13)
        wb(1'h1, CIDF_ADR_PAT0, 8'h00, q);
        wb(1'h0, CIDF_ADR_PAT0, 8'h00, q); `CHK(q, 8'h11)
        gap(1'h0, n); `CHK(n, 3)
        gap(1'h1, n); `CHK(n, 21)
        set_init(1'h1);
        wb(1'h1, CIDF_ADR_BTR1, 8'h7f, q);
        // Oscillator source selected, as preferred for low jitter.
        wb(1'h1, CIDF_ADR_CTL1, 8'h80, q);
        set_init(1'h0);
        n = 0;
        repeat (60) begin @(posedge mclk); if (tick === 1'h1) n++; end
        `CHK(n, 0)
        osc_en <= 1'h1;
        gap(1'h1, n); `CHK(n, 75)
        $display("test bit_timing done");
        tx_bit <= 1'h1;
        gap(1'h1, n); gap(1'h1, n); `CHK(sbit, 1'h1)
        node_dom <= 1'h1;
        gap(1'h1, n); gap(1'h1, n); `CHK(sbit, 1'h0)
        // Three samples: a level change in the last quantum before the
        // sample point loses the majority vote for one bit.
        set_init(1'h1);
        wb(1'h1, CIDF_ADR_BTR1, 8'hff, q);
        set_init(1'h0);
        gap(1'h1, n);
        repeat (72) @(posedge mclk);
        node_dom <= 1'h0;
        n = 0;
        do begin @(posedge mclk); n++; end while (spl !== 1'h1 && n < 100);
        `CHK(sbit, 1'h0)
        gap(1'h1, n); `CHK(sbit, 1'h1)
        tx_bit <= 1'h0;
        n = 0;
        do begin @(posedge mclk); n++; end while (tx !== 1'h0 && n < 200);
        `CHK(tx, 1'h0)
        wb(1'h1, CIDF_ADR_CTL0, 8'h06, q);
        @(posedge mclk);
        `CHK(tx, 1'h1)
        $display("test bus_pins done");
        wrap_up;
    end
endmodule // cidf_core_tb_top
`default_nettype wire
